/* hdl/hdlc_fifo_cfg.svh */
// Constants for the HDLC FIFO status block
`ifndef HDLC_FIFO_CFG_SVH
`define HDLC_FIFO_CFG_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define HF_DATA_W 8
`define HF_DEPTH 64
`define HF_AW 6
`define HF_CW 7
`define HF_DEPTH_CNT 7'h40
`define HF_ZERO_CNT 7'h00
`define HF_ONE_CNT 7'h01

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define RX_LIVE_HWM_BIT 1
`define RX_LIVE_DROP_BIT 2
`define RX_LAT_EOP_BIT 0
`define RX_LAT_HWM_BIT 1
`define RX_LAT_OVR_BIT 5
`define TX_LIVE_LWM_BIT 1
`define TX_LAT_EOP_BIT 0
`define TX_LAT_LWM_BIT 1
`define BA_MORE_BIT 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define STATUS_RST 8'h00
`define BA_RST 8'h00

`endif

/* hdl/hdlc_fifo_pkg.sv */
// Types shared by the HDLC FIFO status block
`include "hdlc_fifo_cfg.svh"

package hdlc_fifo_pkg;

   // ----------------------------------------------------------------
   // One FIFO entry: a byte and its end-of-packet mark
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [`HF_DATA_W-1:0] data;
      logic eop;
   } hdlc_byte_t;

   // ----------------------------------------------------------------
   // Latched and live status of one direction
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] live;
      logic [7:0] latched;
   } hdlc_status_t;

endpackage

/* hdl/byte_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides and a flush
`timescale 1ns/10ps

module byte_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 64
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // Occupancy
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic push;
   logic pop;

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   assign count = wr_ptr - rd_ptr;
   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign push = in_valid && in_ready && !flush;
   assign pop = out_valid && out_ready && !flush;
   assign out_data = mem[rd_ptr[AW-1:0]];

   // ----------------------------------------------------------------
   // Pointers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else if (flush) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Data cells are not reset; the pointers make them unreadable
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

endmodule // byte_fifo

/* hdl/hdlc_fifo_status.sv */
// HDLC receive/transmit FIFO watermarks, byte counts and status
`timescale 1ns/10ps
`include "hdlc_fifo_cfg.svh"

module hdlc_fifo_status
   import hdlc_fifo_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Watermark levels
   input wire logic [6:0] rx_fifo_watermark_ctrl,
   input wire logic [6:0] tx_fifo_watermark_ctrl,
   // Receive bytes from the deframer
   input wire logic rx_in_valid,
   input wire hdlc_byte_t rx_in,
   // Receive host read
   output logic rx_rd_valid,
   input wire logic rx_rd_ready,
   output hdlc_byte_t rx_rd_data,
   output logic [7:0] rx_bytes_available,
   // Transmit host write
   input wire logic tx_wr_valid,
   output logic tx_wr_ready,
   input wire hdlc_byte_t tx_wr_data,
   input wire logic tx_space_rd,
   output logic [6:0] tx_space_available,
   // Transmit bytes to the framer
   output logic tx_out_valid,
   input wire logic tx_out_ready,
   output hdlc_byte_t tx_out_data,
   // Status, clear and masks
   output hdlc_status_t rx_status,
   output hdlc_status_t tx_status,
   input wire logic rx_status_wr,
   input wire logic [7:0] rx_status_wdata,
   input wire logic tx_status_wr,
   input wire logic [7:0] tx_status_wdata,
   input wire logic [7:0] rx_irq_mask_five,
   input wire logic [7:0] tx_irq_mask_two,
   // Interrupt
   output logic irq_n
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Set wins over a clear arriving in the same cycle
   function automatic logic [7:0] latch_update(input logic [7:0] cur,
                                               input logic [7:0] set,
                                               input logic clr,
                                               input logic [7:0] mask);
      logic [7:0] keep;
      keep = clr ? ~mask : 8'hFF;
      return (cur & keep) | set;
   endfunction

   // Counter step, wrapping at the counter width
   function automatic logic [`HF_CW-1:0] step_cnt(
      input logic [`HF_CW-1:0] v);
      return v + `HF_ONE_CNT;
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic rx_in_ready;
   logic [`HF_CW-1:0] rx_occ;
   logic [`HF_CW-1:0] tx_occ;
   logic drop_pkt;
   logic overrun;
   logic rx_push;
   logic rx_pop;
   logic tx_pop;
   logic [`HF_CW-1:0] wr_total;
   logic [`HF_CW-1:0] rd_total;
   logic [`HF_CW-1:0] eop_pos [`HF_DEPTH];
   logic [`HF_CW-1:0] eop_wr;
   logic [`HF_CW-1:0] eop_rd;
   logic rx_hwm;
   logic tx_lwm;
   logic rx_hwm_q;
   logic tx_lwm_q;
   logic [7:0] rx_live;
   logic [7:0] tx_live;
   logic [7:0] rx_lat;
   logic [7:0] tx_lat;
   logic [7:0] rx_set;
   logic [7:0] tx_set;
   logic [7:0] next_bytes_available;

   // ----------------------------------------------------------------
   // FIFOs
   // ----------------------------------------------------------------
   byte_fifo #(.WIDTH($bits(hdlc_byte_t)), .DEPTH(`HF_DEPTH)) rx_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .flush(overrun),
      .in_valid(rx_push),
      .in_ready(rx_in_ready),
      .in_data(rx_in),
      .out_valid(rx_rd_valid),
      .out_ready(rx_rd_ready),
      .out_data(rx_rd_data),
      .count(rx_occ)
   );

   byte_fifo #(.WIDTH($bits(hdlc_byte_t)), .DEPTH(`HF_DEPTH)) tx_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .flush(1'b0),
      .in_valid(tx_wr_valid),
      .in_ready(tx_wr_ready),
      .in_data(tx_wr_data),
      .out_valid(tx_out_valid),
      .out_ready(tx_out_ready),
      .out_data(tx_out_data),
      .count(tx_occ)
   );

   // ----------------------------------------------------------------
   // Receive overrun
   // ----------------------------------------------------------------
   // The deframer cannot stall, so a full FIFO means overrun
   assign overrun = rx_in_valid && !drop_pkt && !rx_in_ready;
   assign rx_push = rx_in_valid && !drop_pkt && rx_in_ready;
   assign rx_pop = rx_rd_valid && rx_rd_ready && !overrun;
   assign tx_pop = tx_out_valid && tx_out_ready;

   // Rest of the damaged packet is dropped up to its end mark
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         drop_pkt <= 1'b0;
      end else if (overrun) begin
         drop_pkt <= !rx_in.eop;
      end else if (drop_pkt && rx_in_valid && rx_in.eop) begin
         drop_pkt <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Packet end tracking
   // ----------------------------------------------------------------
   // Queue of end positions; at most one per stored byte, never overflows
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_total <= `HF_ZERO_CNT;
         rd_total <= `HF_ZERO_CNT;
         eop_wr <= `HF_ZERO_CNT;
         eop_rd <= `HF_ZERO_CNT;
      end else if (overrun) begin
         wr_total <= `HF_ZERO_CNT;
         rd_total <= `HF_ZERO_CNT;
         eop_wr <= `HF_ZERO_CNT;
         eop_rd <= `HF_ZERO_CNT;
      end else begin
         if (rx_push) begin
            wr_total <= step_cnt(wr_total);
         end
         if (rx_push && rx_in.eop) begin
            eop_wr <= step_cnt(eop_wr);
         end
         if (rx_pop) begin
            rd_total <= step_cnt(rd_total);
         end
         if (rx_pop && rx_rd_data.eop) begin
            eop_rd <= step_cnt(eop_rd);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rx_push && rx_in.eop && !overrun) begin
         eop_pos[eop_wr[`HF_AW-1:0]] <= step_cnt(wr_total);
      end
   end

   // ----------------------------------------------------------------
   // Receive bytes available
   // ----------------------------------------------------------------
   always_comb begin
      if (eop_wr != eop_rd) begin
         // Up to and including the first stored end mark
         next_bytes_available =
            {1'b0, eop_pos[eop_rd[`HF_AW-1:0]] - rd_total};
      end else begin
         // Start or continuation, packet still open
         next_bytes_available = {rx_occ != `HF_ZERO_CNT, rx_occ};
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_bytes_available <= `BA_RST;
      end else begin
         rx_bytes_available <= next_bytes_available;
      end
   end

   // ----------------------------------------------------------------
   // Transmit space available
   // ----------------------------------------------------------------
   // Frozen during a host read so the value cannot tear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_space_available <= `HF_DEPTH_CNT;
      end else if (!tx_space_rd) begin
         tx_space_available <= `HF_DEPTH_CNT - tx_occ;
      end
   end

   // ----------------------------------------------------------------
   // Watermarks and live status
   // ----------------------------------------------------------------
   assign rx_hwm = rx_occ > rx_fifo_watermark_ctrl;
   assign tx_lwm = tx_occ < tx_fifo_watermark_ctrl;

   // Receive live bits; unused positions read zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_live <= `STATUS_RST;
      end else begin
         rx_live <= `STATUS_RST;
         rx_live[`RX_LIVE_HWM_BIT] <= rx_hwm;
         rx_live[`RX_LIVE_DROP_BIT] <= drop_pkt || overrun;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_live <= `STATUS_RST;
      end else begin
         tx_live <= `STATUS_RST;
         tx_live[`TX_LIVE_LWM_BIT] <= tx_lwm;
      end
   end

   // Previous levels, for the rising-edge event detect
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_hwm_q <= 1'b0;
         tx_lwm_q <= 1'b0;
      end else begin
         rx_hwm_q <= rx_hwm;
         tx_lwm_q <= tx_lwm;
      end
   end

   // ----------------------------------------------------------------
   // Latched status
   // ----------------------------------------------------------------
   always_comb begin
      rx_set = `STATUS_RST;
      tx_set = `STATUS_RST;
      rx_set[`RX_LAT_EOP_BIT] = rx_push && rx_in.eop;
      rx_set[`RX_LAT_HWM_BIT] = rx_hwm && !rx_hwm_q;
      rx_set[`RX_LAT_OVR_BIT] = overrun;
      tx_set[`TX_LAT_EOP_BIT] = tx_pop && tx_out_data.eop;
      tx_set[`TX_LAT_LWM_BIT] = tx_lwm && !tx_lwm_q;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_lat <= `STATUS_RST;
         tx_lat <= `STATUS_RST;
      end else begin
         rx_lat <= latch_update(rx_lat, rx_set, rx_status_wr,
                                rx_status_wdata);
         tx_lat <= latch_update(tx_lat, tx_set, tx_status_wr,
                                tx_status_wdata);
      end
   end

   assign rx_status = '{live: rx_live, latched: rx_lat};
   assign tx_status = '{live: tx_live, latched: tx_lat};

   // ----------------------------------------------------------------
   // Interrupt
   // ----------------------------------------------------------------
   // One cycle behind the latched bits, glitch free from a flop
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_n <= 1'b1;
      end else begin
         irq_n <= !(|(rx_lat & rx_irq_mask_five) ||
                    |(tx_lat & tx_irq_mask_two));
      end
   end

endmodule // hdlc_fifo_status

/* tb/hdlc_fifo_status_chk.sv */
// Port-level assertions for the HDLC FIFO status block
`timescale 1ns/10ps
module hdlc_fifo_status_chk
   import hdlc_fifo_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Watched ports
   input wire logic rx_in_valid,
   input wire logic rx_rd_valid,
   input wire logic [7:0] rx_bytes_available,
   input wire logic tx_space_rd,
   input wire logic [6:0] tx_space_available,
   input wire hdlc_status_t rx_status,
   input wire hdlc_status_t tx_status,
   input wire logic rx_status_wr,
   input wire logic [7:0] rx_status_wdata,
   input wire logic tx_status_wr,
   input wire logic [7:0] rx_irq_mask_five,
   input wire logic [7:0] tx_irq_mask_two,
   input wire logic irq_n
);
   logic pend;
   assign pend = |{rx_status.latched & rx_irq_mask_five,
      tx_status.latched & tx_irq_mask_two};
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   irq_set_a: assert property (pend |=> !irq_n)
      else $error("irq_n high with a pending event");
   irq_release_a: assert property (!pend && !irq_n |=> irq_n)
      else $error("irq_n held low with nothing pending");
   ovr_hold_a: assert property (rx_status.latched[5] && !rx_status_wr
      |=> rx_status.latched[5])
      else $error("overrun bit lost without a clear");
   lwm_hold_a: assert property (tx_status.latched[1] && !tx_status_wr
      |=> tx_status.latched[1])
      else $error("low-mark bit lost without a clear");
   ovr_clear_a: assert property (rx_status_wr && rx_status_wdata[5]
      && !rx_in_valid && !$past(rx_in_valid)
      |=> !rx_status.latched[5])
      else $error("overrun bit not cleared");
   space_freeze_a: assert property ($past(tx_space_rd)
      |-> $stable(tx_space_available))
      else $error("space count moved during a read");
   space_range_a: assert property (tx_space_available <= 7'h40)
      else $error("space count above the FIFO size");
   empty_count_a: assert property (!rx_rd_valid [*3]
      |-> rx_bytes_available[6:0] == 7'h00)
      else $error("byte count nonzero on an empty FIFO");
   hwm_latch_a: assert property ($rose(rx_status.live[1])
      |-> ##[0:2] rx_status.latched[1])
      else $error("high-mark event not latched");
   lwm_latch_a: assert property ($rose(tx_status.live[1])
      |-> ##[0:2] tx_status.latched[1])
      else $error("low-mark event not latched");
endmodule // hdlc_fifo_status_chk

/* tb/hdlc_framer_sink.sv */
// Framer-side drain model for the transmit FIFO
`timescale 1ns/10ps
module hdlc_framer_sink
   import hdlc_fifo_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Pacing
   input wire logic stall,
   input wire logic slow,
   // Transmit stream
   input wire logic tx_out_valid,
   output logic tx_out_ready,
   input wire hdlc_byte_t tx_out_data
);
   hdlc_byte_t got[$];
   // Random gaps when slow, so the FIFO sees a stalling framer
   always @(posedge clock) begin
      if (rst_n && tx_out_valid && tx_out_ready) begin
         got.push_back(tx_out_data);
      end
      tx_out_ready <= rst_n && !stall && (!slow || $urandom_range(1, 0) == 1);
   end
endmodule // hdlc_framer_sink

/* tb/hdlc_fifo_status_test.sv */
// Self-checking bench for the HDLC FIFO status block
`timescale 1ns/10ps
module hdlc_fifo_status_test
   import hdlc_fifo_pkg::*;
;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [6:0] rx_fifo_watermark_ctrl = 7'h00;
   logic [6:0] tx_fifo_watermark_ctrl = 7'h00;
   logic rx_in_valid = 1'b0, rx_rd_ready = 1'b0, tx_wr_valid = 1'b0;
   logic tx_space_rd = 1'b0, rx_status_wr = 1'b0, tx_status_wr = 1'b0;
   logic stall = 1'b1, slow = 1'b0, drop = 1'b0;
   hdlc_byte_t rx_in = '0, tx_wr_data = '0, rx_rd_data, tx_out_data;
   logic [7:0] rx_status_wdata = 8'h00, tx_status_wdata = 8'h00;
   logic [7:0] rx_irq_mask_five = 8'h00, tx_irq_mask_two = 8'h00;
   logic rx_rd_valid, tx_wr_ready, tx_out_valid, tx_out_ready, irq_n;
   logic [7:0] rx_bytes_available;
   logic [6:0] tx_space_available;
   hdlc_status_t rx_status, tx_status;
   hdlc_byte_t rxq[$], txq[$];
   hdlc_byte_t wb;
   int errors = 0, total_checks = 0;

   hdlc_fifo_status dut (
      .clock(clock),
      .rst_n(rst_n),
      .rx_fifo_watermark_ctrl(rx_fifo_watermark_ctrl),
      .tx_fifo_watermark_ctrl(tx_fifo_watermark_ctrl),
      .rx_in_valid(rx_in_valid),
      .rx_in(rx_in),
      .rx_rd_valid(rx_rd_valid),
      .rx_rd_ready(rx_rd_ready),
      .rx_rd_data(rx_rd_data),
      .rx_bytes_available(rx_bytes_available),
      .tx_wr_valid(tx_wr_valid),
      .tx_wr_ready(tx_wr_ready),
      .tx_wr_data(tx_wr_data),
      .tx_space_rd(tx_space_rd),
      .tx_space_available(tx_space_available),
      .tx_out_valid(tx_out_valid),
      .tx_out_ready(tx_out_ready),
      .tx_out_data(tx_out_data),
      .rx_status(rx_status),
      .tx_status(tx_status),
      .rx_status_wr(rx_status_wr),
      .rx_status_wdata(rx_status_wdata),
      .tx_status_wr(tx_status_wr),
      .tx_status_wdata(tx_status_wdata),
      .rx_irq_mask_five(rx_irq_mask_five),
      .tx_irq_mask_two(tx_irq_mask_two),
      .irq_n(irq_n)
   );
   hdlc_framer_sink sink (
      .clock(clock),
      .rst_n(rst_n),
      .stall(stall),
      .slow(slow),
      .tx_out_valid(tx_out_valid),
      .tx_out_ready(tx_out_ready),
      .tx_out_data(tx_out_data)
   );

   initial forever #5 clock = ~clock;

   task print_verdict;
      if (errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Bytes up to the first stored end, else all with the open mark
   function automatic logic [7:0] ba_exp();
      int n;
      n = 0;
      foreach (rxq[i]) begin
         n++;
         if (rxq[i].eop) return 8'(n);
      end
      return 8'h80 | 8'(n);
   endfunction

   task rest(input int n);
      @(posedge clock);
      rx_in_valid <= 1'b0;
      tx_wr_valid <= 1'b0;
      rx_rd_ready <= 1'b0;
      rx_status_wr <= 1'b0;
      tx_status_wr <= 1'b0;
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask

   // Model: full FIFO flushes and drops the rest of the packet
   task rx_burst(input int n, input logic e_last);
      hdlc_byte_t b;
      for (int i = 0; i < n; i++) begin
         b = '{data: 8'($urandom), eop: e_last && i == n - 1};
         @(posedge clock);
         rx_in_valid <= 1'b1;
         rx_in <= b;
         if (rxq.size() == 64) begin
            rxq.delete();
            drop = !b.eop;
         end else if (drop) drop = !b.eop;
         else rxq.push_back(b);
      end
   endtask

   task rx_pop(input int n);
      @(posedge clock);
      rx_rd_ready <= 1'b1;
      repeat (n) begin
         @(negedge clock);
         chk("rx_head", {1'b1, rxq.pop_front()}, {rx_rd_valid, rx_rd_data});
      end
      rest(2);
   endtask

   task clr(input logic rx, input logic [7:0] w);
      @(posedge clock);
      rx_status_wr <= rx;
      tx_status_wr <= !rx;
      rx_status_wdata <= w;
      tx_status_wdata <= w;
      rest(3);
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      print_verdict;
   end

   initial begin
      void'($urandom(25));
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      rest(1);
      chk("irq_n", 1'b1, irq_n);
      chk("rx_status", 16'h0000, rx_status);
      chk("tx_space", 7'h40, tx_space_available);
      chk("rx_count", 8'h00, rx_bytes_available);
      // ---------------------------------------------------------
      // Transmit low mark, fill to refusal, drain
      // ---------------------------------------------------------
      @(posedge clock);
      tx_fifo_watermark_ctrl <= 7'h05;
      tx_irq_mask_two <= 8'h02;
      rest(3);
      chk("tx_live", 1'b1, tx_status.live[1]);
      chk("irq_n", 1'b0, irq_n);
      clr(1'b0, 8'h02);
      chk("tx_latch", 1'b0, tx_status.latched[1]);
      chk("tx_live", 1'b1, tx_status.live[1]);
      chk("irq_n", 1'b1, irq_n);
      for (int i = 0; i < 65; i++) begin
         @(posedge clock);
         wb = '{data: 8'($urandom), eop: i == 63};
         tx_wr_valid <= 1'b1;
         tx_wr_data <= wb;
         if (i < 64) txq.push_back(wb);
      end
      rest(2);
      chk("tx_ready", 1'b0, tx_wr_ready);
      chk("tx_space", 7'h00, tx_space_available);
      chk("tx_live", 1'b0, tx_status.live[1]);
      @(posedge clock);
      tx_space_rd <= 1'b1;
      stall <= 1'b0;
      slow <= 1'b1;
      repeat (8) @(posedge clock);
      @(negedge clock);
      chk("tx_space", 7'h00, tx_space_available);
      @(posedge clock);
      tx_space_rd <= 1'b0;
      for (int i = 0; i < 900 && sink.got.size() < 64; i++) @(posedge clock);
      rest(3);
      chk("tx_space", 7'h40, tx_space_available);
      chk("tx_latch", 1'b1, tx_status.latched[1]);
      chk("tx_end", 1'b1, tx_status.latched[0]);
      chk("tx_total", 16'd64, sink.got.size());
      foreach (txq[i]) chk("tx_out", txq[i], sink.got[i]);
      clr(1'b0, 8'hFF);
      chk("irq_n", 1'b1, irq_n);
      // ---------------------------------------------------------
      // Receive counts, high mark, overrun
      // ---------------------------------------------------------
      @(posedge clock);
      rx_fifo_watermark_ctrl <= 7'h0A;
      rx_irq_mask_five <= 8'h22;
      rx_burst(3, 1'b1);
      rx_burst(12, 1'b0);
      rest(3);
      chk("rx_count", ba_exp(), rx_bytes_available);
      chk("rx_live", 1'b1, rx_status.live[1]);
      chk("irq_n", 1'b0, irq_n);
      clr(1'b1, 8'h02);
      chk("rx_live", 1'b1, rx_status.live[1]);
      chk("irq_n", 1'b1, irq_n);
      rx_pop(3);
      chk("rx_end", 1'b1, rx_status.latched[0]);
      chk("rx_count", ba_exp(), rx_bytes_available);
      rx_pop(2);
      chk("rx_live", 1'b0, rx_status.live[1]);
      chk("rx_count", ba_exp(), rx_bytes_available);
      rx_burst(55, 1'b0);
      rest(2);
      chk("rx_latch", 1'b1, rx_status.latched[5]);
      chk("rx_drop", 1'b1, rx_status.live[2]);
      chk("rx_valid", 1'b0, rx_rd_valid);
      chk("irq_n", 1'b0, irq_n);
      rx_burst(3, 1'b1);
      rx_burst(2, 1'b1);
      rest(3);
      chk("rx_count", ba_exp(), rx_bytes_available);
      chk("rx_drop", 1'b0, rx_status.live[2]);
      clr(1'b1, 8'hFF);
      chk("irq_n", 1'b1, irq_n);
      rx_pop(2);
      print_verdict;
   end
endmodule // hdlc_fifo_status_test

bind hdlc_fifo_status hdlc_fifo_status_chk chk_i (
   .clock(clock),
   .rst_n(rst_n),
   .rx_in_valid(rx_in_valid),
   .rx_rd_valid(rx_rd_valid),
   .rx_bytes_available(rx_bytes_available),
   .tx_space_rd(tx_space_rd),
   .tx_space_available(tx_space_available),
   .rx_status(rx_status),
   .tx_status(tx_status),
   .rx_status_wr(rx_status_wr),
   .rx_status_wdata(rx_status_wdata),
   .tx_status_wr(tx_status_wr),
   .rx_irq_mask_five(rx_irq_mask_five),
   .tx_irq_mask_two(tx_irq_mask_two),
   .irq_n(irq_n)
);
